//--- core/cnpg_map.svh
`ifndef CNPG_MAP_SVH
`define CNPG_MAP_SVH
`define CNPG_ADDR_W 4
`define CNPG_IDX_EXPANSION 4'h6
`define CNPG_IDX_NP_TX 4'h7
`define CNPG_IDX_NP_RX 4'h8
`define CNPG_IDX_GIG_CTRL 4'h9
`define CNPG_IDX_EVENTS 4'ha
`define CNPG_NP_TX_RST 16'h2001
`define CNPG_NP_TX_CLR 16'h0000
`define CNPG_NP_TX_WMASK 16'hb7ff
`define CNPG_NP_RX_RST 16'h0000
`define CNPG_GIG_WMASK 16'hffff
`define CNPG_TM_JIT_MASTER 3'h2
`define CNPG_TM_JIT_SLAVE 3'h3
`define CNPG_EXP_LOCAL_NP 16'h0004
`define CNPG_EV_SWRST 0
`define CNPG_EV_RESTART 1
`define CNPG_EV_PWRUP 2
`endif

//--- core/cnpg_pkg.sv
package cnpg_pkg;
   typedef enum logic [2:0] {
      CNPG_TM_NORMAL,
      CNPG_TM_WAVEFORM,
      CNPG_TM_JITTER_M,
      CNPG_TM_JITTER_S,
      CNPG_TM_DISTORT,
      CNPG_TM_RSV5,
      CNPG_TM_RSV6,
      CNPG_TM_RSV7
   } cnpg_test_mode_t;

   typedef struct packed {
      logic next_page;
      logic reserved;
      logic message_page;
      logic ack2;
      logic toggle;
      logic [10:0] message;
   } cnpg_word_t;

   typedef struct packed {
      cnpg_test_mode_t test_mode;
      logic ms_manual;
      logic ms_value;
      logic port_type;
      logic adv_full;
      logic adv_half;
      logic [7:0] reserved;
   } cnpg_gig_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } cnpg_avl_req_t;
endpackage

//--- core/cnpg_sync2.sv
`timescale 1ns/1ps
module cnpg_sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

//--- core/cnpg_resolve.sv
`timescale 1ns/1ps
module cnpg_resolve
   import cnpg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input cnpg_gig_t active,
   output logic want_master,
   output logic manual
);
   // manual overrides preference; preference is only a hint to resolution
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         want_master <= 1'b0;
         manual <= 1'b0;
      end else begin
         manual <= active.ms_manual;
         want_master <= active.ms_manual ? active.ms_value : active.port_type;
      end
   end
endmodule

//--- core/cnpg_regs.sv
`timescale 1ns/1ps
`include "cnpg_map.svh"
module cnpg_regs
   import cnpg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic master_slave_strap,
   input wire logic autoneg_strap_bit0,
   input wire logic link_up,
   input wire logic sw_reset,
   input wire logic an_restart,
   input wire logic power_down,
   input wire logic rx_page_valid,
   input wire logic [15:0] rx_page_word,
   input wire logic tx_toggle,
   input wire logic tx_page_sent,
   input wire logic rx_clk_pin,
   input wire logic tx_clk_normal,
   output logic [15:0] tx_page_word,
   output logic np_loaded,
   output logic [2:0] test_mode,
   output logic tx_clk_sel_rx,
   output logic gig_adv_full,
   output logic gig_adv_half,
   output logic ms_manual,
   output logic ms_want_master,
   output logic tx_clk_sel
);
   // ---------------------------------------------------------------
   // pin inputs
   // ---------------------------------------------------------------
   logic strap_ms_s, strap_an_s, rx_clk_s, tx_clk_s;

   cnpg_sync2 #(.W(4)) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d({master_slave_strap, autoneg_strap_bit0, rx_clk_pin, tx_clk_normal}),
      .q({strap_ms_s, strap_an_s, rx_clk_s, tx_clk_s})
   );

   // ---------------------------------------------------------------
   // bus access, one wait state on every access
   // ---------------------------------------------------------------
   cnpg_avl_req_t req;
   logic ack_q;
   logic wr_go, rd_go;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
                  writedata: avs_writedata, byteenable: avs_byteenable};
   assign wr_go = req.write && ack_q;
   assign rd_go = req.read && ack_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (req.read || req.write) && !ack_q;
      end
   end

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] be, input logic [15:0] wm);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}} & wm;
      merge16 = (old & ~lanes) | (nw & lanes);
   endfunction

   // ---------------------------------------------------------------
   // strap capture after reset release
   // ---------------------------------------------------------------
   logic [2:0] boot_q;
   logic boot_done;

   assign boot_done = boot_q[2];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         boot_q <= 3'h0;
      end else if (!boot_done) begin
         boot_q <= boot_q + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // update events
   // ---------------------------------------------------------------
   logic link_q, pd_q, link_fail, pwr_up, update_ev;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         link_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         link_q <= link_up;
         pd_q <= power_down;
      end
   end

   assign link_fail = link_q && !link_up;
   assign pwr_up = pd_q && !power_down;
   assign update_ev = sw_reset || an_restart || pwr_up || link_fail;

   // ---------------------------------------------------------------
   // next page transmit
   // ---------------------------------------------------------------
   cnpg_word_t np_tx_q;
   logic np_loaded_q;
   logic wr_tx;

   assign wr_tx = wr_go && req.address == `CNPG_IDX_NP_TX;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         np_tx_q <= `CNPG_NP_TX_RST;
      end else if (sw_reset) begin
         np_tx_q <= `CNPG_NP_TX_RST;
      end else if (link_fail) begin
         // a dropped link wipes the page outright; soft reset restores defaults
         np_tx_q <= `CNPG_NP_TX_CLR;
      end else if (wr_tx) begin
         np_tx_q <= merge16(np_tx_q, req.writedata[15:0], req.byteenable[1:0],
                            `CNPG_NP_TX_WMASK);
      end else begin
         np_tx_q.toggle <= tx_toggle;
         np_tx_q.reserved <= 1'b0;
      end
   end

   // a write in the cycle of a send keeps the new page loaded
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         np_loaded_q <= 1'b0;
      end else if (wr_tx) begin
         np_loaded_q <= 1'b1;
      end else if (tx_page_sent || link_fail || sw_reset) begin
         np_loaded_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // link partner next page and page received
   // ---------------------------------------------------------------
   logic [15:0] np_rx_q;
   logic page_rx_q;
   logic rd_exp;

   assign rd_exp = rd_go && req.address == `CNPG_IDX_EXPANSION;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         np_rx_q <= `CNPG_NP_RX_RST;
      end else if (sw_reset) begin
         np_rx_q <= `CNPG_NP_RX_RST;
      end else if (rx_page_valid) begin
         np_rx_q <= rx_page_word;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         page_rx_q <= 1'b0;
      end else if (rx_page_valid) begin
         page_rx_q <= 1'b1;
      end else if (rd_exp) begin
         page_rx_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // gigabit control, shadow and active copies
   // ---------------------------------------------------------------
   cnpg_gig_t gig_shadow_q, gig_active_q;
   logic wr_gig;

   assign wr_gig = wr_go && req.address == `CNPG_IDX_GIG_CTRL;

   // software sees the shadow; the port runs on the active copy, except test mode and the jitter clock select, taken from the shadow
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gig_shadow_q <= '0;
         gig_shadow_q.adv_full <= 1'b1;
      end else if (!boot_done) begin
         gig_shadow_q.ms_value <= strap_ms_s;
         gig_shadow_q.port_type <= strap_ms_s;
         gig_shadow_q.adv_half <= strap_an_s;
      end else if (wr_gig) begin
         gig_shadow_q <= merge16(gig_shadow_q, req.writedata[15:0], req.byteenable[1:0],
                                 `CNPG_GIG_WMASK);
      end else if (an_restart) begin
         gig_shadow_q.test_mode <= CNPG_TM_NORMAL;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gig_active_q <= '0;
         gig_active_q.adv_full <= 1'b1;
      end else if (!boot_done || update_ev) begin
         gig_active_q <= gig_shadow_q;
      end else begin
         gig_active_q.test_mode <= gig_shadow_q.test_mode;
      end
   end

   logic res_master, res_manual;

   cnpg_resolve u_resolve (
      .clk(clk),
      .rst_b(rst_b),
      .active(gig_active_q),
      .want_master(res_master),
      .manual(res_manual)
   );

   // ---------------------------------------------------------------
   // outputs and read data
   // ---------------------------------------------------------------
   logic jitter;

   assign jitter = gig_shadow_q.test_mode == `CNPG_TM_JIT_MASTER ||
                   gig_shadow_q.test_mode == `CNPG_TM_JIT_SLAVE;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_page_word <= `CNPG_NP_TX_RST;
         np_loaded <= 1'b0;
         test_mode <= 3'h0;
         tx_clk_sel_rx <= 1'b0;
         tx_clk_sel <= 1'b0;
         gig_adv_full <= 1'b1;
         gig_adv_half <= 1'b0;
         ms_manual <= 1'b0;
         ms_want_master <= 1'b0;
      end else begin
         tx_page_word <= np_tx_q;
         np_loaded <= np_loaded_q;
         test_mode <= gig_shadow_q.test_mode;
         tx_clk_sel_rx <= jitter;
         tx_clk_sel <= jitter ? rx_clk_s : tx_clk_s;
         gig_adv_full <= gig_active_q.adv_full;
         gig_adv_half <= gig_active_q.adv_half;
         ms_manual <= res_manual;
         ms_want_master <= res_master;
      end
   end

   logic [15:0] rd_mux;

   always_comb begin
      rd_mux = 16'h0000;
      unique case (req.address)
         `CNPG_IDX_EXPANSION: rd_mux = `CNPG_EXP_LOCAL_NP | {14'h0, page_rx_q, 1'b0};
         `CNPG_IDX_NP_TX: rd_mux = np_tx_q;
         `CNPG_IDX_NP_RX: rd_mux = np_rx_q;
         `CNPG_IDX_GIG_CTRL: rd_mux = gig_shadow_q;
         `CNPG_IDX_EVENTS: rd_mux = {15'h0, np_loaded_q};
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0;
      end else if (req.read && !ack_q) begin
         avs_readdata <= {16'h0, rd_mux};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((req.read || req.write) && !ack_q);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_np_load_flag: assert property (@(posedge clk) disable iff (!rst_b)
      wr_tx |=> np_loaded_q) else $error("page loaded flag not set");
   a_link_fail_clr: assert property (@(posedge clk) disable iff (!rst_b)
      link_fail && !sw_reset |=> np_tx_q == `CNPG_NP_TX_CLR) else $error("tx page not cleared");
   a_rx_mirror: assert property (@(posedge clk) disable iff (!rst_b)
      rx_page_valid && !sw_reset |=> np_rx_q == $past(rx_page_word))
      else $error("partner page not captured");
   a_rx_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !rx_page_valid && !sw_reset |=> $stable(np_rx_q)) else $error("partner page changed");
   a_restart_tm: assert property (@(posedge clk) disable iff (!rst_b)
      an_restart && !wr_gig && boot_done |=> gig_shadow_q.test_mode == 3'h0)
      else $error("test mode not cleared");
   a_pending_hold: assert property (@(posedge clk) disable iff (!rst_b)
      boot_done && !update_ev |=> $stable(gig_active_q.adv_full) && $stable(gig_active_q.ms_manual))
      else $error("pending setting applied early");
   a_jitter_sel: assert property (@(posedge clk) disable iff (!rst_b)
      jitter |=> tx_clk_sel_rx) else $error("jitter clock not selected");
   a_page_latch: assert property (@(posedge clk) disable iff (!rst_b)
      rx_page_valid |=> page_rx_q) else $error("page received not latched");
   a_manual_force: assert property (@(posedge clk) disable iff (!rst_b)
      gig_active_q.ms_manual |=> res_master == $past(gig_active_q.ms_value))
      else $error("manual value not applied");
   a_sw_tx_reset: assert property (@(posedge clk) disable iff (!rst_b)
      sw_reset |=> np_tx_q == `CNPG_NP_TX_RST) else $error("tx page not reset");
   a_tx_rsv_zero: assert property (@(posedge clk) disable iff (!rst_b)
      !np_tx_q.reserved) else $error("reserved tx bit set");
   a_toggle_ro: assert property (@(posedge clk) disable iff (!rst_b)
      !wr_tx && !link_fail && !sw_reset |=> np_tx_q.toggle == $past(tx_toggle))
      else $error("toggle bit not tracking");
   a_np_sent_clr: assert property (@(posedge clk) disable iff (!rst_b)
      tx_page_sent && !wr_tx |=> !np_loaded_q) else $error("page loaded flag not cleared");
   a_rx_swrst: assert property (@(posedge clk) disable iff (!rst_b)
      sw_reset |=> np_rx_q == `CNPG_NP_RX_RST) else $error("partner page not reset");
   a_page_clear: assert property (@(posedge clk) disable iff (!rst_b)
      rd_exp && !rx_page_valid |=> !page_rx_q) else $error("page received not cleared");
   a_update_apply: assert property (@(posedge clk) disable iff (!rst_b)
      update_ev |=> gig_active_q == $past(gig_shadow_q)) else $error("pending setting lost");
   a_auto_pref: assert property (@(posedge clk) disable iff (!rst_b)
      !gig_active_q.ms_manual |=> res_master == $past(gig_active_q.port_type))
      else $error("port preference not applied");
   a_strap_load: assert property (@(posedge clk) disable iff (!rst_b)
      !boot_done |=> gig_shadow_q.ms_value == $past(strap_ms_s))
      else $error("strap not loaded");
   a_half_strap: assert property (@(posedge clk) disable iff (!rst_b)
      !boot_done |=> gig_shadow_q.adv_half == $past(strap_an_s))
      else $error("half duplex strap not loaded");
   a_tm_follow: assert property (@(posedge clk) disable iff (!rst_b)
      1'b1 |=> test_mode == $past(gig_shadow_q.test_mode))
      else $error("test mode output stale");
   a_clk_pick: assert property (@(posedge clk) disable iff (!rst_b)
      jitter |=> tx_clk_sel == $past(rx_clk_s)) else $error("receive clock not chosen");
   // bus answer: the wait state always ends one cycle after the request
   a_wait_one: assert property (@(posedge clk) disable iff (!rst_b)
      avs_waitrequest == !ack_q) else $error("wait state out of step");
endmodule

//--- testbench/cnpg_partner.sv
`timescale 1ns/1ps
// ----------------------------------------
// far-side autoneg model
// ----------------------------------------
module cnpg_partner #(
   parameter int ACK_DLY = 10
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic np_loaded,
   output logic tx_page_sent,
   output logic rx_page_valid,
   output logic [15:0] rx_page_word
);
   int cnt;

   initial begin
      rx_page_valid = 1'b0;
      rx_page_word = 16'h0000;
   end

   // slow consumer: takes the loaded page only after ACK_DLY cycles
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         tx_page_sent <= 1'b0;
      end else begin
         cnt <= np_loaded ? cnt + 1 : 0;
         tx_page_sent <= (cnt == ACK_DLY);
      end
   end

   // one accepted word; afterwards the lines show the inverse, not a stale copy
   task send_page(input logic [15:0] w);
      @(posedge clk);
      rx_page_valid <= 1'b1;
      rx_page_word <= w;
      @(posedge clk);
      rx_page_valid <= 1'b0;
      rx_page_word <= ~w;
   endtask
endmodule

//--- testbench/copper_next_page_and_gig_control_regs_tb.sv
`timescale 1ns/1ps
module copper_next_page_and_gig_control_regs_tb;
   import cnpg_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h3;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic ms_strap = 1'b1;
   logic an_strap = 1'b0;
   logic link_up = 1'b1;
   logic sw_reset = 1'b0;
   logic an_restart = 1'b0;
   logic power_down = 1'b0;
   logic rx_page_valid, tx_page_sent, np_loaded, tx_clk_sel_rx, tx_clk_sel;
   logic [15:0] rx_page_word, tx_page_word;
   logic tx_toggle = 1'b0;
   logic rx_clk_pin = 1'b1;
   logic tx_clk_normal = 1'b0;
   logic [2:0] test_mode;
   logic gig_adv_full, gig_adv_half, ms_manual, ms_want_master;
   int n_fail = 0;
   int num_checks = 0;

   always #20 clk = ~clk;

   cnpg_regs dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .master_slave_strap(ms_strap), .autoneg_strap_bit0(an_strap), .link_up(link_up),
      .sw_reset(sw_reset), .an_restart(an_restart), .power_down(power_down),
      .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word), .tx_toggle(tx_toggle),
      .tx_page_sent(tx_page_sent), .rx_clk_pin(rx_clk_pin), .tx_clk_normal(tx_clk_normal),
      .tx_page_word(tx_page_word), .np_loaded(np_loaded), .test_mode(test_mode),
      .tx_clk_sel_rx(tx_clk_sel_rx), .gig_adv_full(gig_adv_full), .gig_adv_half(gig_adv_half),
      .ms_manual(ms_manual), .ms_want_master(ms_want_master), .tx_clk_sel(tx_clk_sel));

   cnpg_partner #(.ACK_DLY(10)) p (.clk(clk), .rst_b(rst_b), .np_loaded(np_loaded),
      .tx_page_sent(tx_page_sent), .rx_page_valid(rx_page_valid), .rx_page_word(rx_page_word));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task close_out;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // called just after a rising edge; holds the request until waitrequest is seen low
   task bus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask

   task rchk(input logic [3:0] a, input logic [15:0] exp, input string nm);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(nm, q, exp);
   endtask

   // update events: 0 soft reset, 1 autoneg restart, 2 power-up, 3 link drop
   task fire(input int k);
      case (k)
         0: sw_reset <= 1'b1;
         1: an_restart <= 1'b1;
         2: power_down <= 1'b1;
         default: link_up <= 1'b0;
      endcase
      @(posedge clk);
      sw_reset <= 1'b0;
      an_restart <= 1'b0;
      power_down <= 1'b0;
      link_up <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   function automatic logic [3:0] outs_exp(input logic [15:0] v);
      return {v[12], v[12] ? v[11] : v[10], v[9], v[8]};
   endfunction

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [15:0] v, prev;
      logic [2:0] tm;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (7) @(posedge clk);
      rchk(4'h7, 16'h2001, "tx page reset");
      rchk(4'h8, 16'h0000, "partner page reset");
      rchk(4'h9, 16'h0e00, "gig ctrl reset");
      chk("adv full/half", {gig_adv_full, gig_adv_half}, 16'h0002);
      rchk(4'hb, 16'h0000, "unmapped");
      prev = 16'h0e00;
      for (int k = 0; k < 4; k++) begin
         v = (k % 2 == 0) ? 16'h1900 : 16'h0a00;
         wr(4'h9, v);
         repeat (3) @(posedge clk);
         chk("held pending", {ms_manual, ms_want_master, gig_adv_full, gig_adv_half},
            outs_exp(prev));
         fire(k);
         chk("applied", {ms_manual, ms_want_master, gig_adv_full, gig_adv_half},
            outs_exp(v));
         prev = v;
      end
      wr(4'h7, 16'hffff);
      repeat (2) @(posedge clk);
      chk("page loaded", np_loaded, 16'h0001);
      rchk(4'h7, 16'hb7ff, "tx page ro bits");
      repeat (20) @(posedge clk);
      chk("page taken", np_loaded, 16'h0000);
      chk("tx word out", tx_page_word, 16'hb7ff);
      fire(3);
      rchk(4'h7, 16'h0000, "link fail clear");
      tx_toggle <= 1'b1;
      repeat (2) @(posedge clk);
      rchk(4'h7, 16'h0800, "toggle ro");
      tx_toggle <= 1'b0;
      p.send_page(16'ha5a5);
      repeat (3) @(posedge clk);
      wr(4'h8, 16'hffff);
      rchk(4'h8, 16'ha5a5, "partner page");
      rchk(4'h6, 16'h0006, "page received");
      rchk(4'h6, 16'h0004, "page rcv cleared");
      for (int m = 0; m < 5; m++) begin
         tm = m[2:0];
         wr(4'h9, {tm, 13'h0a00});
         repeat (4) @(posedge clk);
         chk("test mode", test_mode, tm);
         chk("jitter sel", tx_clk_sel_rx, (tm == 3'h2 || tm == 3'h3));
         chk("clock chosen", tx_clk_sel, (tm == 3'h2 || tm == 3'h3));
         rchk(4'h9, {tm, 13'h0a00}, "gig readback");
      end
      wr(4'h9, {3'h3, 13'h0a00});
      fire(0);
      chk("mode kept", test_mode, 16'h0003);
      fire(1);
      chk("mode cleared", test_mode, 16'h0000);
      fire(0);
      close_out();
   end

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      close_out();
   end
endmodule
